// file: verilog/sos_params.svh
`ifndef SOS_PARAMS_SVH
`define SOS_PARAMS_SVH
// ***************************************************************
// Register byte offsets
// ***************************************************************
`define SOS_REG_SELECT   8'h00
`define SOS_REG_ZERO     8'h04
`define SOS_REG_SPEED    8'h08
`define SOS_REG_BANDS    8'h0c
`define SOS_REG_TORQUE   8'h10
`define SOS_REG_MOTHEAT  8'h14
`define SOS_REG_SINK     8'h18
`define SOS_REG_RISE     8'h1c
`define SOS_REG_FALL     8'h20
`define SOS_REG_OVLD     8'h24
`define SOS_REG_MAXSPD   8'h28
`define SOS_REG_CALIB    8'h2c
`define SOS_REG_STATUS   8'h30
`define SOS_REG_LIVE     8'h34
// ***************************************************************
// Reset values (speeds in 0.1 rpm, bands in 0.1 %, gain in 0.01 %)
// ***************************************************************
`define SOS_SEL_UNUSED   5'h01
`define SOS_ZERO_LVL     16'h0064
`define SOS_BAND_DEF     16'h0005
`define SOS_SPEED_LVL    16'h0000
`define SOS_TRQ_LVL      16'h0000
`define SOS_MOT_TEMP     8'h8c
`define SOS_MOT_BAND     8'h05
`define SOS_SINK_TEMP    8'h4b
`define SOS_SINK_BAND    8'h05
`define SOS_TMR_DLY      16'h0001
`define SOS_OL_LVL       8'h96
`define SOS_OL_TIME      8'h0a
`define SOS_MAXSPD       16'h4650
`define SOS_GAIN_DEF     16'h2710
`define SOS_BIAS_DEF     16'h0000
`define SOS_GAIN_MAX     25000
`define SOS_BIAS_LIM     10000
`define SOS_FULL_SCALE   10000
// ***************************************************************
// Timing
// ***************************************************************
`define SOS_CLK_NS       8
`define SOS_TICK_NS      100000000
`define SOS_TICKS_PER_S  10
`endif

// file: verilog/sos_pkg.sv
package sos_pkg;
  typedef struct packed {
    logic signed [16:0] speed;
    logic signed [16:0] set_speed;
    logic [11:0]        torque;
    logic [11:0]        current_pct;
    logic [7:0]         motor_temp;
    logic [7:0]         sink_temp;
  } sos_meas_t;
  typedef struct packed {
    logic drive_ok;
    logic trip;
    logic running;
    logic regen;
    logic dc_low;
    logic trq_sat;
    logic accel;
    logic timer_in;
  } sos_flags_t;
  typedef enum logic [4:0] {
    FN_UNUSED = 5'h01, FN_READY, FN_ZERO, FN_SPD, FN_SPD_ABS, FN_ARRIVE, FN_TIMER,
    FN_UNDERV, FN_RUN, FN_REGEN, FN_MOT_OH, FN_SINK_OH, FN_AGREE, FN_TRQ, FN_TRQ_LIM,
    FN_OVLD, FN_STOP, FN_STEADY
  } sos_func_t;
  typedef enum logic {CAL_IDLE, CAL_EDIT} sos_cal_t;
endpackage

// file: verilog/sos_top.sv
// How it works
// - Three outputs each pick one function code.
// - Output is on exactly while function true.
// - Code one keeps the output off.
// - Ready drops at once on trip.
// - Zero speed when speed at or below level.
// - Zero speed band scales with maximum speed.
// - Signed and magnitude speed level detection.
// - Speed level band scales with maximum speed.
// - Arrival when speed within band of set.
// - Agree when speed equals set, with band.
// - Timer output follows input with two delays.
// - Undervoltage while link voltage below level.
// - Run while drive runs the motor.
// - Regeneration while motor returns energy.
// - Motor heat warning, thermistor input only.
// - Heatsink heat warning above threshold.
// - Torque detect at regulator output level.
// - Torque limit while regulator saturated.
// - Overload compares current to rated percent.
// - Overload sets and clears after warning time.
// - Stop while drive stays stopped.
// - Steady while running at constant speed.
// - Gain edit shows live value, commits on enter.
// - Bias edit shows live value, stores on enter.
//
// Our own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "sos_params.svh"
module sos_top
  import sos_pkg::*;
#(
  parameter int TICK_CYCLES = `SOS_TICK_NS / `SOS_CLK_NS
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_b,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // Drive measurements and states
  input  wire sos_meas_t          meas,
  input  wire sos_flags_t         flg,
  // Keypad calibration
  input  wire logic signed [15:0] analog_input_one,
  input  wire logic               cal_bias,
  input  wire logic               edit_key,
  input  wire logic               commit_key,
  input  wire logic               up_key,
  input  wire logic               down_key,
  output logic signed [15:0]      live_pct,
  output logic signed [15:0]      pending_value,
  // Status outputs
  output logic                    relay_output_one,
  output logic                    relay_output_two,
  output logic                    open_collector_output
);
  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [4:0]         sel_q [3];
  logic [15:0]        zero_speed_threshold, zero_speed_hysteresis;
  logic signed [15:0] speed_threshold;
  logic [15:0]        speed_hysteresis, arrival_hysteresis, match_hysteresis;
  logic [15:0]        torque_threshold, torque_hysteresis;
  logic [7:0]         motor_heat_threshold, motor_heat_hysteresis;
  logic [7:0]         heatsink_threshold, heatsink_hysteresis;
  logic               therm_en_q;
  logic [15:0]        rise_delay, fall_delay, max_speed_setting;
  logic [7:0]         ol_level_q, ol_time_q;
  logic [15:0]        gain_q;
  logic signed [15:0] bias_q;
  logic [31:0]        fn_q, fn_d;
  logic               ack_q, wr_en;
  logic [31:0]        rd_d, wr_word;
  sos_cal_t           cal_q;

  assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wb_ack_o = ack_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction
  assign wr_word = merge(rd_d, wb_dat_i, wb_sel_i);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      wb_dat_o <= rd_d;
    end
  end

  always_comb begin
    case (wb_adr_i & 8'hfc)
      `SOS_REG_SELECT:  rd_d = {11'h000, sel_q[2], 3'h0, sel_q[1], 3'h0, sel_q[0]};
      `SOS_REG_ZERO:    rd_d = {zero_speed_hysteresis, zero_speed_threshold};
      `SOS_REG_SPEED:   rd_d = {speed_hysteresis, speed_threshold};
      `SOS_REG_BANDS:   rd_d = {match_hysteresis, arrival_hysteresis};
      `SOS_REG_TORQUE:  rd_d = {torque_hysteresis, torque_threshold};
      `SOS_REG_MOTHEAT: rd_d = {15'h0000, therm_en_q, motor_heat_hysteresis,
                                motor_heat_threshold};
      `SOS_REG_SINK:    rd_d = {16'h0000, heatsink_hysteresis, heatsink_threshold};
      `SOS_REG_RISE:    rd_d = {16'h0000, rise_delay};
      `SOS_REG_FALL:    rd_d = {16'h0000, fall_delay};
      `SOS_REG_OVLD:    rd_d = {16'h0000, ol_time_q, ol_level_q};
      `SOS_REG_MAXSPD:  rd_d = {16'h0000, max_speed_setting};
      `SOS_REG_CALIB:   rd_d = {bias_q, gain_q};
      `SOS_REG_STATUS:  rd_d = {7'h00, cal_q, fn_q[18:0], 2'h0, open_collector_output,
                                relay_output_two, relay_output_one};
      `SOS_REG_LIVE:    rd_d = {live_pct, pending_value};
      default:          rd_d = 32'h0000_0000;
    endcase
  end

  // Configuration registers; writes to unmapped or read-only words are ignored.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) begin
        sel_q[i] <= `SOS_SEL_UNUSED;
      end
      zero_speed_threshold <= `SOS_ZERO_LVL;
      zero_speed_hysteresis <= `SOS_BAND_DEF;
      speed_threshold <= `SOS_SPEED_LVL;
      speed_hysteresis <= `SOS_BAND_DEF;
      arrival_hysteresis <= `SOS_BAND_DEF;
      match_hysteresis <= `SOS_BAND_DEF;
      torque_threshold <= `SOS_TRQ_LVL;
      torque_hysteresis <= `SOS_BAND_DEF;
      motor_heat_threshold <= `SOS_MOT_TEMP;
      motor_heat_hysteresis <= `SOS_MOT_BAND;
      therm_en_q <= 1'b0;
      heatsink_threshold <= `SOS_SINK_TEMP;
      heatsink_hysteresis <= `SOS_SINK_BAND;
      rise_delay <= `SOS_TMR_DLY;
      fall_delay <= `SOS_TMR_DLY;
      ol_level_q <= `SOS_OL_LVL;
      ol_time_q <= `SOS_OL_TIME;
      max_speed_setting <= `SOS_MAXSPD;
    end else if (wr_en) begin
      case (wb_adr_i & 8'hfc)
        `SOS_REG_SELECT:
          {sel_q[2], sel_q[1], sel_q[0]} <=
            {wr_word[20:16], wr_word[12:8], wr_word[4:0]};
        `SOS_REG_ZERO:    {zero_speed_hysteresis, zero_speed_threshold} <= wr_word;
        `SOS_REG_SPEED:   {speed_hysteresis, speed_threshold} <= wr_word;
        `SOS_REG_BANDS:   {match_hysteresis, arrival_hysteresis} <= wr_word;
        `SOS_REG_TORQUE:  {torque_hysteresis, torque_threshold} <= wr_word;
        `SOS_REG_MOTHEAT:
          {therm_en_q, motor_heat_hysteresis, motor_heat_threshold} <= wr_word[16:0];
        `SOS_REG_SINK:    {heatsink_hysteresis, heatsink_threshold} <= wr_word[15:0];
        `SOS_REG_RISE:   rise_delay <= wr_word[15:0];
        `SOS_REG_FALL:   fall_delay <= wr_word[15:0];
        `SOS_REG_OVLD:    {ol_time_q, ol_level_q} <= wr_word[15:0];
        `SOS_REG_MAXSPD: max_speed_setting <= wr_word[15:0];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // Time base: 0.1 s tick and 1 s tick
  // ***************************************************************
  logic [31:0] tick_cnt_q;
  logic [3:0]  sec_cnt_q;
  logic        tick, sec_tick;
  assign tick     = (tick_cnt_q == 32'(TICK_CYCLES - 1));
  assign sec_tick = tick && (sec_cnt_q == 4'(`SOS_TICKS_PER_S - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 32'h0000_0000;
      sec_cnt_q <= 4'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (tick) begin
        sec_cnt_q <= sec_tick ? 4'h0 : sec_cnt_q + 4'h1;
      end
    end
  end

  // ***************************************************************
  // Timer output and overload delays
  // ***************************************************************
  logic        tmr_out_q, ol_q, ol_above;
  logic [15:0] tmr_cnt_q;
  logic [7:0]  ol_cnt_q;
  assign ol_above = meas.current_pct > {4'h0, ol_level_q};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_out_q <= 1'b0;
      tmr_cnt_q <= 16'h0000;
    end else if (flg.timer_in == tmr_out_q) begin
      tmr_cnt_q <= 16'h0000;
    end else if (tick) begin
      if (tmr_cnt_q + 16'h0001 >= (flg.timer_in ? rise_delay : fall_delay)) begin
        tmr_out_q <= flg.timer_in;
        tmr_cnt_q <= 16'h0000;
      end else begin
        tmr_cnt_q <= tmr_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ol_q <= 1'b0;
      ol_cnt_q <= 8'h00;
    end else if (ol_above == ol_q) begin
      ol_cnt_q <= 8'h00;
    end else if (sec_tick) begin
      if (ol_cnt_q + 8'h01 >= ol_time_q) begin
        ol_q <= ol_above;
        ol_cnt_q <= 8'h00;
      end else begin
        ol_cnt_q <= ol_cnt_q + 8'h01;
      end
    end
  end

  // ***************************************************************
  // Status functions
  // ***************************************************************
  // Above-type comparator: sets at the level, releases only below level minus band.
  function automatic logic hyst_hi(input logic prev, input int x, input int lvl,
                                   input int band);
    return prev ? (x >= lvl - band) : (x >= lvl);
  endfunction

  int spd, aspd, diff, lvl, spd_band, zero_band, arr_band, agr_band;
  always_comb begin
    spd  = int'(meas.speed);
    aspd = (spd < 0) ? -spd : spd;
    diff = spd - int'(meas.set_speed);
    diff = (diff < 0) ? -diff : diff;
    lvl  = int'(speed_threshold);
    zero_band = int'(zero_speed_hysteresis) * int'(max_speed_setting) / 1000;
    spd_band  = int'(speed_hysteresis) * int'(max_speed_setting) / 1000;
    arr_band  = int'(arrival_hysteresis) * int'(max_speed_setting) / 1000;
    agr_band  = int'(match_hysteresis) * int'(max_speed_setting) / 1000;
    fn_d = 32'h0000_0000;
    fn_d[FN_READY]  = flg.drive_ok && !flg.trip;
    fn_d[FN_ZERO]   = fn_q[FN_ZERO] ? (aspd <= int'(zero_speed_threshold) + zero_band)
                                    : (aspd <= int'(zero_speed_threshold));
    fn_d[FN_SPD]    = (lvl >= 0) ? hyst_hi(fn_q[FN_SPD], spd, lvl, spd_band)
                                 : hyst_hi(fn_q[FN_SPD], -spd, -lvl, spd_band);
    fn_d[FN_SPD_ABS] = hyst_hi(fn_q[FN_SPD_ABS], aspd, (lvl < 0) ? -lvl : lvl, spd_band);
    fn_d[FN_ARRIVE] = diff <= arr_band;
    fn_d[FN_TIMER]  = tmr_out_q;
    fn_d[FN_UNDERV] = flg.dc_low;
    fn_d[FN_RUN]    = flg.running;
    fn_d[FN_REGEN]  = flg.regen;
    fn_d[FN_MOT_OH] = therm_en_q && hyst_hi(fn_q[FN_MOT_OH], int'(meas.motor_temp) - 1,
                        int'(motor_heat_threshold), int'(motor_heat_hysteresis));
    fn_d[FN_SINK_OH] = hyst_hi(fn_q[FN_SINK_OH], int'(meas.sink_temp) - 1,
                        int'(heatsink_threshold), int'(heatsink_hysteresis));
    fn_d[FN_AGREE]  = fn_q[FN_AGREE] ? (diff <= agr_band) : (diff == 0);
    fn_d[FN_TRQ]    = hyst_hi(fn_q[FN_TRQ], int'(meas.torque), int'(torque_threshold),
                              int'(torque_hysteresis));
    fn_d[FN_TRQ_LIM] = flg.trq_sat;
    fn_d[FN_OVLD]   = ol_q;
    fn_d[FN_STOP]   = !flg.running;
    fn_d[FN_STEADY] = flg.running && !flg.accel;
  end

  logic [2:0] out_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fn_q <= 32'h0000_0000;
      out_q <= 3'h0;
    end else begin
      fn_q <= fn_d;
      for (int i = 0; i < 3; i++) begin
        out_q[i] <= (sel_q[i] == `SOS_SEL_UNUSED) ? 1'b0 : fn_q[sel_q[i]];
      end
    end
  end
  assign {open_collector_output, relay_output_two, relay_output_one} = out_q;

  // ***************************************************************
  // Keypad calibration of gain and bias
  // ***************************************************************
  int live;
  logic signed [15:0] pend_q;
  always_comb begin
    if (cal_q == CAL_EDIT && !cal_bias) begin
      live = int'(analog_input_one) * int'(pend_q) / `SOS_FULL_SCALE + int'(bias_q);
    end else if (cal_q == CAL_EDIT) begin
      live = int'(analog_input_one) * int'(gain_q) / `SOS_FULL_SCALE + int'(pend_q);
    end else begin
      live = int'(analog_input_one) * int'(gain_q) / `SOS_FULL_SCALE + int'(bias_q);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cal_q <= CAL_IDLE;
      pend_q <= 16'sh0000;
      gain_q <= `SOS_GAIN_DEF;
      bias_q <= `SOS_BIAS_DEF;
      live_pct <= 16'sh0000;
    end else begin
      live_pct <= 16'(live);
      if (wr_en && (wb_adr_i & 8'hfc) == `SOS_REG_CALIB) begin
        {bias_q, gain_q} <= merge({bias_q, gain_q}, wb_dat_i, wb_sel_i);
      end
      case (cal_q)
        CAL_IDLE: begin
          if (edit_key) begin
            cal_q <= CAL_EDIT;
            pend_q <= cal_bias ? bias_q : signed'(gain_q);
          end
        end
        CAL_EDIT: begin
          if (commit_key) begin
            cal_q <= CAL_IDLE;
            if (cal_bias) begin
              bias_q <= pend_q;
            end else begin
              gain_q <= pend_q;
            end
          end else if (up_key && int'(pend_q) < (cal_bias ? `SOS_BIAS_LIM : `SOS_GAIN_MAX)) begin
            pend_q <= pend_q + 16'sh0001;
          end else if (down_key && int'(pend_q) > (cal_bias ? -`SOS_BIAS_LIM : 0)) begin
            pend_q <= pend_q - 16'sh0001;
          end
        end
        default: cal_q <= CAL_IDLE;
      endcase
    end
  end
  assign pending_value = (cal_q == CAL_EDIT) ? pend_q : (cal_bias ? bias_q : gain_q);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_unused;
    @(posedge mclk) disable iff (!rst_b) (sel_q[0] == `SOS_SEL_UNUSED) |=> !relay_output_one;
  endproperty
  a_unused: assert property (p_unused) else $error("unused code drove output");

  property p_run;
    @(posedge mclk) disable iff (!rst_b)
      (sel_q[1] == 5'h09 && flg.running) ##1 (sel_q[1] == 5'h09) |=> relay_output_two;
  endproperty
  a_run: assert property (p_run) else $error("run not shown on output");

  property p_ready;
    @(posedge mclk) disable iff (!rst_b)
      (sel_q[2] == 5'h02 && flg.trip) ##1 (sel_q[2] == 5'h02) |=> !open_collector_output;
  endproperty
  a_ready: assert property (p_ready) else $error("ready held during trip");

  property p_stop;
    @(posedge mclk) disable iff (!rst_b)
      (sel_q[0] == 5'h11 && !flg.running) ##1 (sel_q[0] == 5'h11) |=> relay_output_one;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not shown");

  property p_zero;
    @(posedge mclk) disable iff (!rst_b)
      (aspd <= int'(zero_speed_threshold)) |=> fn_q[FN_ZERO];
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed missed");

  property p_heat;
    @(posedge mclk) disable iff (!rst_b) !therm_en_q |=> !fn_q[FN_MOT_OH];
  endproperty
  a_heat: assert property (p_heat) else $error("motor heat without thermistor");

  property p_timer;
    @(posedge mclk) disable iff (!rst_b) $changed(tmr_out_q) |-> $past(tick);
  endproperty
  a_timer: assert property (p_timer) else $error("timer moved off tick");

  property p_ovld;
    @(posedge mclk) disable iff (!rst_b) $changed(ol_q) |-> $past(sec_tick && ol_above != ol_q);
  endproperty
  a_ovld: assert property (p_ovld) else $error("overload moved early");

  property p_gain;
    @(posedge mclk) disable iff (!rst_b)
      (cal_q == CAL_EDIT && !commit_key && !wr_en) |=> $stable(gain_q) && $stable(bias_q);
  endproperty
  a_gain: assert property (p_gain) else $error("calibration stored without enter");
endmodule // sos_top
`default_nettype wire

// file: tb/sos_ext_equip.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// External equipment wired to the status terminals
// ***************************************************************
module sos_ext_equip (
  // Clock
  input  wire logic       mclk,
  // Status terminals
  input  wire logic       relay_one,
  input  wire logic       relay_two,
  input  wire logic       oc_out,
  // Sensed terminal levels
  output logic [2:0]      seen
);
  // The equipment senses the contacts once per clock, as a plc scan would.
  always_ff @(posedge mclk) begin
    seen <= {relay_one, relay_two, oc_out};
  end
endmodule // sos_ext_equip
`default_nettype wire

// file: tb/sos_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sos_params.svh"
module sos_top_tb;
  import sos_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_b, wb_cyc, wb_stb, wb_we, cal_bias;
  logic [7:0]        wb_adr;
  logic [31:0]       wb_dat, wb_dat_o, rd;
  logic              wb_ack_o, r1, r2, oc;
  sos_meas_t         meas;
  sos_flags_t        flg;
  logic signed [15:0] ain, live_pct, pending_value;
  logic [3:0]        keys;
  logic [2:0]        seen;
  int                errors, checked;
  logic [4:0]        codes [5] = '{5'h09, 5'h0a, 5'h08, 5'h0f, 5'h02};
  logic [7:0]        bits [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h80};

  always #4 mclk = ~mclk;

  sos_top #(.TICK_CYCLES(10)) u_dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas(meas), .flg(flg),
    .analog_input_one(ain), .cal_bias(cal_bias), .edit_key(keys[3]),
    .commit_key(keys[2]), .up_key(keys[1]), .down_key(keys[0]), .live_pct(live_pct),
    .pending_value(pending_value), .relay_output_one(r1), .relay_output_two(r2),
    .open_collector_output(oc));
  sos_ext_equip u_equip (.mclk(mclk), .relay_one(r1), .relay_two(r2), .oc_out(oc),
    .seen(seen));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      complete_run;
    end
    rd = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask

  task automatic settle;
    repeat (4) @(posedge mclk);
  endtask

  task automatic wait_chk(input int n, input logic [2:0] exp);
    repeat (n) @(posedge mclk);
    chk(seen, exp);
  endtask

  task automatic press(input logic [3:0] k);
    @(posedge mclk);
    keys <= k;
    @(posedge mclk);
    keys <= 4'h0;
  endtask

  task automatic complete_run;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_regs;
    bus(0, `SOS_REG_SELECT, 0); chk(rd, 32'h0001_0101);
    bus(0, `SOS_REG_ZERO, 0); chk(rd, 32'h0005_0064);
    bus(0, `SOS_REG_MOTHEAT, 0); chk(rd, 32'h0000_058c);
    bus(0, `SOS_REG_SINK, 0); chk(rd, 32'h0000_054b);
    bus(0, `SOS_REG_RISE, 0); chk(rd, 32'h0000_0001);
    bus(0, `SOS_REG_OVLD, 0); chk(rd, 32'h0000_0a96);
    bus(0, `SOS_REG_CALIB, 0); chk(rd, 32'h0000_2710);
    bus(1, 8'h3c, 32'hffff_ffff);
    bus(0, 8'h3c, 0); chk(rd, 32'h0);
  endtask

  task automatic t_flags;
    for (int i = 0; i < 5; i++) begin
      bus(1, `SOS_REG_SELECT, {11'h0, codes[i], 3'h0, codes[i], 3'h0, codes[i]});
      flg <= 8'h00;
      settle; chk(seen, 3'b000);
      flg <= ~bits[i];
      settle; chk(seen, 3'b000);
      flg <= bits[i];
      settle; chk(seen, 3'b111);
    end
    flg <= 8'hc0;
    settle; chk(seen, 3'b000);
    bus(1, `SOS_REG_SELECT, 32'h0001_1211);
    flg <= 8'h00;
    settle; chk(seen, 3'b100);
    flg <= 8'h20;
    settle; chk(seen, 3'b010);
    flg <= 8'h22;
    settle; chk(seen, 3'b000);
  endtask

  task automatic t_zero;
    bus(1, `SOS_REG_SELECT, 32'h0001_0301);
    meas.speed <= 17'sd100;
    settle; chk(seen, 3'b010);
    meas.speed <= 17'sd150;
    settle; chk(seen, 3'b010);
    meas.speed <= 17'sd300;
    settle; chk(seen, 3'b000);
  endtask

  task automatic t_speed;
    bus(1, `SOS_REG_SPEED, 32'h0005_03e8);
    bus(1, `SOS_REG_SELECT, 32'h000d_0504);
    meas.speed <= -17'sd1200;
    meas.set_speed <= -17'sd1200;
    settle; chk(seen, 3'b011);
    meas.speed <= 17'sd1200;
    settle; chk(seen, 3'b110);
  endtask

  task automatic t_heat;
    bus(1, `SOS_REG_SELECT, 32'h000c_010b);
    meas.sink_temp <= 8'd76;
    settle; chk(seen, 3'b001);
    meas.sink_temp <= 8'd71;
    settle; chk(seen, 3'b001);
    meas.sink_temp <= 8'd69;
    settle; chk(seen, 3'b000);
    meas.sink_temp <= 8'd75;
    settle; chk(seen, 3'b000);
    meas.motor_temp <= 8'd141;
    settle; chk(seen, 3'b000);
    bus(1, `SOS_REG_MOTHEAT, 32'h0001_058c);
    settle; chk(seen, 3'b100);
  endtask

  task automatic t_cal;
    cal_bias <= 1'b0;
    ain <= 16'sd10000;
    press(4'h8);
    press(4'h2);
    press(4'h2);
    settle; chk(pending_value, 16'sd10002);
    chk(live_pct, 16'sd10002);
    bus(0, `SOS_REG_CALIB, 0); chk(rd, 32'h0000_2710);
    press(4'h4);
    bus(0, `SOS_REG_CALIB, 0); chk(rd, 32'h0000_2712);
    cal_bias <= 1'b1;
    ain <= 16'sd0;
    press(4'h8);
    press(4'h2);
    press(4'h2);
    press(4'h1);
    settle; chk(pending_value, 16'sd1);
    chk(live_pct, 16'sd1);
    press(4'h4);
    bus(0, `SOS_REG_CALIB, 0); chk(rd, 32'h0001_2712);
  endtask

  task automatic t_timer;
    bus(1, `SOS_REG_RISE, 32'h0000_0003);
    bus(1, `SOS_REG_SELECT, 32'h0001_0107);
    flg <= 8'h01;
    wait_chk(20, 3'b000);
    wait_chk(20, 3'b100);
    flg <= 8'h00;
    wait_chk(16, 3'b000);
  endtask

  task automatic t_ovld;
    bus(1, `SOS_REG_OVLD, 32'h0000_0296);
    bus(1, `SOS_REG_SELECT, 32'h0001_0110);
    meas.current_pct <= 12'd200;
    wait_chk(100, 3'b000);
    wait_chk(120, 3'b100);
    meas.current_pct <= 12'd150;
    wait_chk(100, 3'b100);
    wait_chk(120, 3'b000);
  endtask

  initial begin
    {rst_b, wb_cyc, wb_stb, wb_we, cal_bias, keys} = '0;
    {wb_adr, wb_dat, meas, flg, ain} = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs;
    t_flags;
    t_zero;
    t_speed;
    t_heat;
    t_cal;
    t_timer;
    t_ovld;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    complete_run;
  end
endmodule // sos_top_tb
`default_nettype wire
